//--- pll_prescaler_and_status_mux.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
// Notes on behaviour
// - mode 4/5 alternates 4 and 5 with nonzero swallow count, else 4.
// - mode 8/9 alternates 8 and 9 with nonzero swallow count, else 8.
// - mode 16/17 alternates 16 and 17 with nonzero count, else 16.
// - mode 32/33 is the reset default, likewise with 32 and 33.
// - a selector code puts the delayed feedback divider on the pin.
// - a selector code puts the delayed reference divider on the pin.
// - pfd up and down pulses each have their own selector code.
module pll_prescaler_and_status_mux
   import pll_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   input  wire logic       feedback_delayed,
   input  wire logic       reference_delayed,
   input  wire logic       pfd_up,
   input  wire logic       pfd_down,
   output logic            status_pin,
   output logic            prescaler_pulse
);
   import pll_pkg::*;

   prescaler_mode_t mode;
   logic [5:0]      sel;
   logic [5:0]      swallow;
   logic [7:0]      feedback_count;
   logic            status_lock;
   logic            modulus_high;
   logic [5:0]      swallow_cnt;
   logic            swallow_pulse;
   logic            next_status;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode           <= prescaler_mode_t'(prescaler_reset);
         sel            <= sel_reset;
         swallow        <= swallow_reset;
         feedback_count <= feedback_reset;
         status_lock    <= 1'b0;
      end else if (wr) begin
         unique case (addr)
            prescaler_ctrl_addr:
               mode <= prescaler_mode_t'(wdata[2:0]);
            status_pin_select_addr: begin
               if (!status_lock)
                  sel <= wdata[7:sel_lsb];
            end
            swallow_count_addr:  swallow        <= wdata[5:0];
            feedback_count_addr: feedback_count <= wdata;
            status_lock_addr:    status_lock    <= wdata[status_lock_bit];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            prescaler_ctrl_addr:    rdata <= {5'h00, mode};
            status_pin_select_addr: rdata <= {sel, 2'b00};
            swallow_count_addr:     rdata <= {2'b00, swallow};
            feedback_count_addr:    rdata <= feedback_count;
            status_lock_addr:       rdata <= {status_lock, 7'h00};
            default:                rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   pll_prescaler u_prescaler (
      .clk          (clk),
      .rstn         (rstn),
      .mode         (mode),
      .swallow      (swallow),
      .pulse        (prescaler_pulse),
      .modulus_high (modulus_high)
   );

   // swallow counter, toggles once every swallow prescaler pulses, on every pulse when swallow is zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         swallow_cnt   <= 6'h00;
         swallow_pulse <= 1'b0;
      end else if (prescaler_pulse) begin
         if (swallow_cnt + 6'd1 >= swallow) begin
            swallow_cnt   <= 6'h00;
            swallow_pulse <= ~swallow_pulse;
         end else begin
            swallow_cnt <= swallow_cnt + 6'd1;
         end
      end
   end

   // ----------------------------------------
   // status pin selector
   // ----------------------------------------
   always_comb begin
      unique case (sel)
         sel_feedback:  next_status = feedback_delayed;
         sel_reference: next_status = reference_delayed;
         sel_swallow:   next_status = swallow_pulse;
         sel_prescaler: next_status = prescaler_pulse;
         sel_pfd_up:    next_status = pfd_up;
         sel_pfd_down:  next_status = pfd_down;
         default:       next_status = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         status_pin <= 1'b0;
      else
         status_pin <= next_status;
   end
endmodule : pll_prescaler_and_status_mux

//--- pll_pkg.sv
package pll_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] prescaler_ctrl_addr    = 8'h16;
   localparam logic [7:0] status_pin_select_addr = 8'h17;
   localparam logic [7:0] swallow_count_addr     = 8'h15;
   localparam logic [7:0] feedback_count_addr    = 8'h13;
   localparam logic [7:0] status_lock_addr       = 8'h1d;
   localparam int         status_lock_bit        = 7;
   localparam int         sel_lsb                = 2;
   localparam logic [2:0] prescaler_reset        = 3'h6;
   localparam logic [5:0] sel_reset              = 6'h00;
   localparam logic [5:0] swallow_reset          = 6'h00;
   localparam logic [7:0] feedback_reset         = 8'h04;

   // ----------------------------------------
   // prescaler modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      fixed_div1  = 3'b000,
      fixed_div2  = 3'b001,
      dual_mod2_3 = 3'b010,
      dual_mod4_5 = 3'b011,
      dual_mod8_9 = 3'b100,
      dual_mod16  = 3'b101,
      dual_mod32  = 3'b110,
      fixed_div3  = 3'b111
   } prescaler_mode_t;

   // ----------------------------------------
   // status pin selector codes
   // ----------------------------------------
   typedef enum logic [5:0] {
      sel_ground     = 6'h00,
      sel_feedback   = 6'h01,
      sel_reference  = 6'h02,
      sel_swallow    = 6'h03,
      sel_prescaler  = 6'h04,
      sel_pfd_up     = 6'h05,
      sel_pfd_down   = 6'h06
   } status_sel_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;
endpackage : pll_pkg

//--- pll_prescaler.sv
`timescale 1ns/100ps
module pll_prescaler
   import pll_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire prescaler_mode_t mode,
   input  wire logic [5:0]      swallow,
   output logic                 pulse,
   output logic                 modulus_high
);
   import pll_pkg::*;
   logic [5:0] cnt;
   logic [5:0] base;
   logic       dual;

   // ----------------------------------------
   // ratio decode
   // ----------------------------------------
   always_comb begin
      dual = 1'b1;
      unique case (mode)
         fixed_div1:  begin base = 6'd1;  dual = 1'b0; end
         fixed_div2:  begin base = 6'd2;  dual = 1'b0; end
         fixed_div3:  begin base = 6'd3;  dual = 1'b0; end
         dual_mod2_3: base = 6'd2;
         dual_mod4_5: base = 6'd4;
         dual_mod8_9: base = 6'd8;
         dual_mod16:  base = 6'd16;
         dual_mod32:  base = 6'd32;
      endcase
   end

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt          <= 6'h00;
         pulse        <= 1'b0;
         modulus_high <= 1'b0;
      end else begin
         pulse <= 1'b0;
         if (cnt + 6'd1 >= base + {5'h00, modulus_high}) begin
            cnt   <= 6'h00;
            pulse <= 1'b1;
            // alternate moduli only with nonzero swallow count
            modulus_high <= dual
                            && (swallow != 6'h00)
                            && !modulus_high;
         end else begin
            cnt <= cnt + 6'd1;
         end
      end
   end
endmodule : pll_prescaler

//--- pll_mux_checker.sv
`timescale 1ns/100ps
module pll_mux_checker
   import pll_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       feedback_delayed,
   input wire logic       reference_delayed,
   input wire logic       pfd_up,
   input wire logic       pfd_down,
   input wire logic       status_pin,
   input wire logic       prescaler_pulse
);
   logic [5:0] s;
   logic [2:0] m;
   logic       lk, z;
   logic [6:0] q, g, h;
   function automatic int base(logic [2:0] k);
      return k == 3'h0 ? 1 : k == 3'h7 ? 3 : k == 3'h1 ? 2 : 1 << (k - 3'h1);
   endfunction : base
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= 6'h00;
         m <= 3'h6;
         lk <= 1'b0;
         z <= 1'b1;
         q <= 7'h00;
         g <= 7'h00;
         h <= 7'h00;
      end else begin
         if (wr && addr == 8'h17 && !lk) s <= wdata[7:2];
         if (wr && addr == 8'h16) m <= wdata[2:0];
         if (wr && addr == 8'h15) z <= wdata[5:0] == 6'h00;
         if (wr && addr == 8'h1d) lk <= wdata[7];
         q <= (wr && addr inside {8'h15, 8'h16}) ? 7'h00 : q + (q != 7'h7f);
         g <= prescaler_pulse ? 7'h00 : g + (g != 7'h7f);
         if (prescaler_pulse) h <= g;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_ground; s == 6'h00 |=> !status_pin; endproperty
   a_ground: assert property (p_ground)
      else $error("pin not low");
   property p_fb;
      s == 6'h01 |=> status_pin == $past(feedback_delayed);
   endproperty
   a_fb: assert property (p_fb)
      else $error("bad feedback");
   property p_ref;
      s == 6'h02 |=> status_pin == $past(reference_delayed);
   endproperty
   a_ref: assert property (p_ref)
      else $error("bad reference");
   property p_pre;
      s == 6'h04 |=> status_pin == $past(prescaler_pulse);
   endproperty
   a_pre: assert property (p_pre)
      else $error("bad prescaler pulse");
   property p_up; s == 6'h05 |=> status_pin == $past(pfd_up); endproperty
   a_up: assert property (p_up)
      else $error("bad up pulse");
   property p_dn; s == 6'h06 |=> status_pin == $past(pfd_down); endproperty
   a_dn: assert property (p_dn)
      else $error("bad down pulse");
   property p_fix;
      q == 7'h7f && prescaler_pulse && (m < 3'h2 || m == 3'h7)
         |-> g == base(m) - 1;
   endproperty
   a_fix: assert property (p_fix)
      else $error("bad fixed period");
   property p_dz;
      q == 7'h7f && prescaler_pulse && m > 3'h1 && m < 3'h7 && z
         |-> g == base(m) - 1;
   endproperty
   a_dz: assert property (p_dz)
      else $error("bad base period");
   property p_da;
      q == 7'h7f && prescaler_pulse && m > 3'h1 && m < 3'h7 && !z
         |-> g + h == 2 * base(m) - 1;
   endproperty
   a_da: assert property (p_da)
      else $error("bad dual period");
   cover property (s == 6'h05 ##1 status_pin);
   cover property (lk && wr && addr == 8'h17);
   cover property (q == 7'h7f && prescaler_pulse && !z && m == 3'h6);
endmodule : pll_mux_checker

//--- status_monitor.sv
`timescale 1ns/100ps
module status_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin,
   output int       rises
);
   initial rises = 0;
   always @(posedge pin) if (rstn) rises++;
endmodule : status_monitor

//--- pll_prescaler_and_status_mux_bench.sv
`timescale 1ns/100ps
module pll_prescaler_and_status_mux_bench;
   import pll_pkg::*;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, fb = 0, rf = 0, up = 0, dn = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic status_pin, prescaler_pulse;
   int seed = 32'h62ee, miscompares = 0, n_tests = 0, rises;
   int i, j, g1, g2, sw, r, e, pe, mr;
   logic [5:0] code [6] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h05, 6'h06};
   pll_prescaler_and_status_mux u_pll_prescaler_and_status_mux (.clk(clk),
      .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .feedback_delayed(fb), .reference_delayed(rf), .pfd_up(up),
      .pfd_down(dn), .status_pin(status_pin), .prescaler_pulse(prescaler_pulse));
   status_monitor u_status_monitor (.clk(clk), .rstn(rstn), .pin(status_pin),
      .rises(rises));
   initial forever #50 clk = ~clk;
   always @(posedge clk) {dn, up, rf, fb} <= 4'($random(seed));
   task chk(logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task put(logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : put
   task get(logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, d);
   endtask : get
   task gap(output int g);
      g = 0;
      do begin
         @(posedge clk);
         #1 g++;
      end while (prescaler_pulse !== 1'b1 && g < 99);
   endtask : gap
   task summarize;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   initial begin
      #2000000 miscompares++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      get(8'h16, 8'h06);
      get(8'h17, 8'h00);
      get(8'h40, 8'h00);
      $display("reset test done");
      for (i = 0; i < 6; i++) begin
         put(8'h17, {code[i], 2'b00});
         repeat (2) @(posedge clk);
         #1 r = rises;
         pe = status_pin;
         mr = 0;
         for (j = 0; j < 20; j++) begin
            e = code[i] == 6'h01 ? fb : code[i] == 6'h02 ? rf :
                code[i] == 6'h04 ? prescaler_pulse :
                code[i] == 6'h05 ? up : code[i] == 6'h06 ? dn : 0;
            @(posedge clk);
            #1 chk(status_pin, e);
            mr += e && !pe;
            pe = e;
         end
         chk(rises - r, mr);
      end
      $display("selector test done");
      put(8'h1d, 8'h80);
      put(8'h17, 8'h04);
      get(8'h17, 8'h18);
      put(8'h1d, 8'h00);
      put(8'h17, 8'h04);
      get(8'h17, 8'h04);
      $display("lock test done");
      for (i = 0; i < 16; i++) begin
         sw = (i % 2) ? ($random(seed) & 8'h3f) | 8'h01 : 0;
         put(8'h15, 8'(sw));
         put(8'h16, 8'(i / 2));
         repeat (140) @(posedge clk);
         gap(g1);
         gap(g1);
         gap(g2);
         r = i < 2 ? 1 : i > 13 ? 3 : i < 4 ? 2 : 1 << (i / 2 - 1);
         e = 2 * r + (sw != 0 && i > 3 && i < 14);
         if (i < 4 || i > 13)
            chk(g1 + g2, e);
         else
            chk(g1 + g2, e);
      end
      $display("prescaler test done");
      summarize();
   end
endmodule : pll_prescaler_and_status_mux_bench
bind pll_prescaler_and_status_mux pll_mux_checker u_pll_mux_checker (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
   .feedback_delayed(feedback_delayed), .reference_delayed(reference_delayed),
   .pfd_up(pfd_up), .pfd_down(pfd_down), .status_pin(status_pin),
   .prescaler_pulse(prescaler_pulse));
